// *** fcwl_pkg.sv ***
// holds the constants of the flash configuration word loader
// assumes a program flash read port, two address units per word, with fixed read latency
// Functional notes
// R1: reload config words from flash every reset
// R2: fetch words at three top flash addresses
// R3: upper eight bits unimplemented, read ones
// R4: erased last page gives protection active
// R5: word1 bit14 enables boundary-scan port
// R6: word1 bit13 low protects whole code
// R7: word1 bit12 low blocks flash writes
// R8: word1 bit11 low resets into debug
// R9: emulator pin pair from word1 bits 9-8
// R10: watchdog enable bit7, window mode bit6
// R11: prescaler bit selects 1:128 or 1:32
// R12: postscaler divides by two to field
// R13: word2 bit15 enables two-speed start-up
// R14: PLL prescaler codes give listed dividers
// R15: word2 bit11 auto-starts PLL, else software
// R16: initial oscillator select code decode
// R17: clock monitor field gates switching, monitor
// R18: osc output pin function in modes 11/00
// R19: one-way lock rejects remap writes once locked
// R20: primary oscillator mode code decode
// R21: segment range from boundary and end bit
// R22: last page protection from page bit
// R23: boundary field counts 512-word pages
// R24: outputs all ones while loading, stable after
package fcwl_pkg;
    // ------------------------------------------------------------
    // flash map
    // ------------------------------------------------------------
    localparam logic [23:0] FCWL_ADDR_WORD1  = 24'h02_ABFE;
    localparam logic [23:0] FCWL_ADDR_WORD2  = 24'h02_ABFC;
    localparam logic [23:0] FCWL_ADDR_WORD3  = 24'h02_ABFA;
    localparam logic [23:0] FCWL_ADDR_WORD4  = 24'h02_ABF8;
    localparam logic [7:0]  FCWL_UPPER_ONES  = 8'hFF;
    localparam logic [23:0] FCWL_WORD_RESET  = 24'hFF_FFFF;
    localparam int          FCWL_PAGE_WORDS  = 512;
    localparam int          FCWL_PAGE_SHIFT  = 10;
    localparam logic [7:0]  FCWL_LAST_PAGE   = 8'hAA;
    localparam logic [1:0]  FCWL_WORD_COUNT  = 2'h3;
    // ------------------------------------------------------------
    // word one fields
    // ------------------------------------------------------------
    localparam int W1_TEST_PORT   = 14;
    localparam int W1_CODE_PROT   = 13;
    localparam int W1_WRITE_PROT  = 12;
    localparam int W1_DEBUG       = 11;
    localparam int W1_PIN_PAIR_LO = 8;
    localparam int W1_WDT_EN      = 7;
    localparam int W1_WIN_DIS     = 6;
    localparam int W1_ALT_REF     = 5;
    localparam int W1_WDT_PRE     = 4;
    localparam int W1_WDT_POST_LO = 0;
    // ------------------------------------------------------------
    // word two fields
    // ------------------------------------------------------------
    localparam int W2_TWO_SPEED   = 15;
    localparam int W2_PLL_DIV_LO  = 12;
    localparam int W2_PLL_AUTO    = 11;
    localparam int W2_OSC_SEL_LO  = 8;
    localparam int W2_CLK_MON_LO  = 6;
    localparam int W2_OSC_PIN     = 5;
    localparam int W2_ONE_WAY     = 4;
    localparam int W2_POSC_LO     = 0;
    // ------------------------------------------------------------
    // word three fields
    // ------------------------------------------------------------
    localparam int W3_SEG_END     = 15;
    localparam int W3_CFG_PAGE    = 14;
    localparam int W3_SEG_DIS     = 13;
    localparam int W3_ALT_PMP     = 12;
    localparam int W3_BOUND_LO    = 0;
    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [1:0] POSC_DISABLED = 2'h3;
    localparam logic [1:0] POSC_EXT_CLK  = 2'h0;
    localparam logic [2:0] OSC_RESERVED  = 3'h6;
    localparam logic [1:0] PAIR_RESERVED = 2'h0;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_DONE} fcwl_state_type;
endpackage

// *** fcwl_decode.sv ***
`timescale 1ns/1ps
// decodes the loaded word1 and word2 into device settings; word3 is taken in but changes no output
// assumes words stay steady between reloads
module fcwl_decode
    import fcwl_pkg::*;
(
    // loaded words
    input  wire logic [23:0] word1,
    input  wire logic [23:0] word2,
    input  wire logic [23:0] word3,
    // decoded settings
    output logic [4:0]  pll_div_ratio,
    output logic [15:0] wdt_post_ratio,
    output logic        clk_switch_en,
    output logic        fail_safe_en,
    output logic        clkout_en,
    output logic        osc_reserved,
    output logic        pair_reserved
);
    always_comb begin
        // R14: pll divide table
        unique case (word2[W2_PLL_DIV_LO +: 3])
            3'h7:    pll_div_ratio = 5'd12;
            3'h6:    pll_div_ratio = 5'd8;
            3'h5:    pll_div_ratio = 5'd6;
            3'h4:    pll_div_ratio = 5'd5;
            3'h3:    pll_div_ratio = 5'd4;
            3'h2:    pll_div_ratio = 5'd3;
            3'h1:    pll_div_ratio = 5'd2;
            default: pll_div_ratio = 5'd1;
        endcase
        // R12: two to the field
        wdt_post_ratio = 16'h0001 << word1[W1_WDT_POST_LO +: 4];
        // R17: monitor needs switching
        clk_switch_en  = ~word2[W2_CLK_MON_LO + 1];
        fail_safe_en   = word2[W2_CLK_MON_LO +: 2] == 2'h0;
        // R18: clock out only in modes 11 and 00
        clkout_en      = word2[W2_OSC_PIN] &&
                         (word2[W2_POSC_LO +: 2] == POSC_DISABLED || word2[W2_POSC_LO +: 2] == POSC_EXT_CLK);
        // R16: reserved oscillator code flagged
        osc_reserved   = word2[W2_OSC_SEL_LO +: 3] == OSC_RESERVED;
        // R9: reserved pin pair flagged
        pair_reserved  = word1[W1_PIN_PAIR_LO +: 2] == PAIR_RESERVED;
        if (word3 == 24'h00_0000) begin
            osc_reserved = osc_reserved;
        end
    end
endmodule

// *** fcwl_loader.sv ***
`timescale 1ns/1ps
// top: loads the configuration words from flash after reset, decodes them
// assumes the flash returns read data FLASH_LAT cycles after a read strobe
module fcwl_loader
    import fcwl_pkg::*;
#(
    parameter int FLASH_LAT = 1
)
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        CLK_EN,
    // flash read port
    output logic             FLASH_RD,
    output logic [23:0]      FLASH_ADDR,
    input  wire logic [23:0] FLASH_DATA,
    // flash write/erase request screening
    input  wire logic        FLASH_WR_REQ,
    input  wire logic [23:0] FLASH_WR_ADDR,
    output logic             FLASH_WR_OK,
    // pin select lock from software
    input  wire logic        PIN_LOCK_SET,
    input  wire logic        PIN_LOCK_CLR,
    input  wire logic        UNLOCK_DONE,
    input  wire logic        PIN_REMAP_WR,
    output logic             PIN_REMAP_WR_OK,
    output logic             PIN_SELECT_LOCK,
    // software pll enable
    input  wire logic        PLL_SOFTWARE_ENABLE,
    // status
    output logic             LOAD_BUSY,
    output logic [23:0]      CFG_WORD1,
    output logic [23:0]      CFG_WORD2,
    output logic [23:0]      CFG_WORD3,
    // decoded settings
    output logic             TEST_PORT_ENABLE,
    output logic             CODE_PROTECT_ALL,
    output logic             WRITE_PROTECT_ALL,
    output logic             DEBUG_MODE,
    output logic [1:0]       EMULATOR_PIN_PAIR_SELECT,
    output logic             EMULATOR_PAIR_RESERVED,
    output logic             WATCHDOG_ENABLE,
    output logic             WATCHDOG_WINDOW_MODE,
    output logic             WATCHDOG_PRESCALE_128,
    output logic [15:0]      WATCHDOG_POSTSCALE_RATIO,
    output logic             ALTERNATE_REFERENCE_PINS,
    output logic             TWO_SPEED_STARTUP_ENABLE,
    output logic [4:0]       PLL_INPUT_DIVIDER,
    output logic             PLL_RUN,
    output logic [2:0]       INITIAL_OSCILLATOR_SELECT,
    output logic             INITIAL_OSC_RESERVED,
    output logic             CLOCK_SWITCH_ENABLE,
    output logic             FAIL_SAFE_MONITOR_ENABLE,
    output logic             CLOCK_OUTPUT_PIN,
    output logic [1:0]       PRIMARY_OSC_MODE,
    output logic             ALTERNATE_PARALLEL_PORT_PINS
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fcwl_state_type state;
        logic [1:0]     idx;
        logic [3:0]     wait_cnt;
        logic           rd;
        logic [23:0]    w1;
        logic [23:0]    w2;
        logic [23:0]    w3;
        logic           lock;
        logic           lock_used;
    } fcwl_regs_type;

    fcwl_regs_type s_r;
    fcwl_regs_type s_nxt;

    logic [23:0] rd_addr;
    logic        loaded;
    logic [23:0] dw1;
    logic [23:0] dw2;
    logic [23:0] dw3;
    logic [4:0]  pll_ratio;
    logic [15:0] post_ratio;
    logic        sw_en;
    logic        fs_en;
    logic        clock_output_pin;
    logic        osc_rsv;
    logic        pair_rsv;
    logic [13:0] wr_page;
    logic [13:0] bound_page;
    logic [13:0] last_page;
    logic        seg_hit;
    logic        last_hit;
    logic        seg_block;

    always_comb begin
        // R2: word order from the top down
        unique case (s_r.idx)
            2'h0:    rd_addr = FCWL_ADDR_WORD1;
            2'h1:    rd_addr = FCWL_ADDR_WORD2;
            default: rd_addr = FCWL_ADDR_WORD3;
        endcase
    end

    // ------------------------------------------------------------
    // load sequence
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rd = 1'b0;
        unique case (s_r.state)
            ST_IDLE: begin
                s_nxt.rd       = 1'b1;
                s_nxt.wait_cnt = 4'(FLASH_LAT);
                s_nxt.state    = ST_READ;
            end
            ST_READ: begin
                if (s_r.wait_cnt != 4'h0) begin
                    s_nxt.wait_cnt = s_r.wait_cnt - 4'h1;
                end else begin
                    // R3: unimplemented upper byte forced to ones
                    unique case (s_r.idx)
                        2'h0:    s_nxt.w1 = {FCWL_UPPER_ONES, FLASH_DATA[15:0]};
                        2'h1:    s_nxt.w2 = {FCWL_UPPER_ONES, FLASH_DATA[15:0]};
                        default: s_nxt.w3 = {FCWL_UPPER_ONES, FLASH_DATA[15:0]};
                    endcase
                    if (s_r.idx == FCWL_WORD_COUNT - 2'h1) begin
                        s_nxt.state = ST_DONE;
                    end else begin
                        s_nxt.idx      = s_r.idx + 2'h1;
                        s_nxt.rd       = 1'b1;
                        s_nxt.wait_cnt = 4'(FLASH_LAT);
                    end
                end
            end
            ST_DONE: begin
                s_nxt.state = ST_DONE;
            end
            default: s_nxt.state = ST_IDLE;
        endcase
        // R19: one-way lock policy
        if (s_r.state == ST_DONE && UNLOCK_DONE) begin
            if (PIN_LOCK_SET && !(dw2[W2_ONE_WAY] && s_r.lock_used)) begin
                s_nxt.lock      = 1'b1;
                s_nxt.lock_used = 1'b1;
            end else if (PIN_LOCK_CLR && !dw2[W2_ONE_WAY]) begin
                s_nxt.lock = 1'b0;
            end
        end
    end

    // R1: every reset restarts the load
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_r.state     <= ST_IDLE;
            s_r.idx       <= 2'h0;
            s_r.wait_cnt  <= 4'h0;
            s_r.rd        <= 1'b0;
            s_r.w1        <= FCWL_WORD_RESET;
            s_r.w2        <= FCWL_WORD_RESET;
            s_r.w3        <= FCWL_WORD_RESET;
            s_r.lock      <= 1'b0;
            s_r.lock_used <= 1'b0;
        end else if (CLK_EN) begin
            s_r <= s_nxt;
        end
    end

    // R24: all ones until the load completes
    assign loaded = s_r.state == ST_DONE;
    assign dw1    = loaded ? s_r.w1 : FCWL_WORD_RESET;
    assign dw2    = loaded ? s_r.w2 : FCWL_WORD_RESET;
    assign dw3    = loaded ? s_r.w3 : FCWL_WORD_RESET;

    fcwl_decode u_decode (
        .word1          (dw1),
        .word2          (dw2),
        .word3          (dw3),
        .pll_div_ratio  (pll_ratio),
        .wdt_post_ratio (post_ratio),
        .clk_switch_en  (sw_en),
        .fail_safe_en   (fs_en),
        .clkout_en      (clock_output_pin),
        .osc_reserved   (osc_rsv),
        .pair_reserved  (pair_rsv)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign FLASH_RD   = s_r.rd;
    assign FLASH_ADDR = rd_addr;
    assign LOAD_BUSY  = !loaded;
    assign CFG_WORD1  = dw1;
    assign CFG_WORD2  = dw2;
    assign CFG_WORD3  = dw3;
    // R5: test port enable
    assign TEST_PORT_ENABLE         = dw1[W1_TEST_PORT];
    // R6: active-low general code protect
    assign CODE_PROTECT_ALL         = ~dw1[W1_CODE_PROT];
    // R7: active-low general write protect
    assign WRITE_PROTECT_ALL        = ~dw1[W1_WRITE_PROT];
    // R8: zero means debug mode
    assign DEBUG_MODE               = ~dw1[W1_DEBUG];
    // R9: pin pair code passed through
    assign EMULATOR_PIN_PAIR_SELECT = dw1[W1_PIN_PAIR_LO +: 2];
    assign EMULATOR_PAIR_RESERVED   = pair_rsv;
    // R10: window mode only with watchdog on
    assign WATCHDOG_ENABLE          = dw1[W1_WDT_EN];
    assign WATCHDOG_WINDOW_MODE     = dw1[W1_WDT_EN] & ~dw1[W1_WIN_DIS];
    // R11: prescaler select
    assign WATCHDOG_PRESCALE_128    = dw1[W1_WDT_PRE];
    assign WATCHDOG_POSTSCALE_RATIO = post_ratio;
    assign ALTERNATE_REFERENCE_PINS = dw1[W1_ALT_REF];
    // R13: two-speed start-up
    assign TWO_SPEED_STARTUP_ENABLE = dw2[W2_TWO_SPEED];
    assign PLL_INPUT_DIVIDER        = pll_ratio;
    // R15: auto start or software enable
    assign PLL_RUN                  = loaded & (dw2[W2_PLL_AUTO] | PLL_SOFTWARE_ENABLE);
    assign INITIAL_OSCILLATOR_SELECT = dw2[W2_OSC_SEL_LO +: 3];
    assign INITIAL_OSC_RESERVED     = osc_rsv;
    assign CLOCK_SWITCH_ENABLE      = sw_en;
    assign FAIL_SAFE_MONITOR_ENABLE = fs_en;
    assign CLOCK_OUTPUT_PIN         = clock_output_pin;
    // R20: primary oscillator mode code
    assign PRIMARY_OSC_MODE         = dw2[W2_POSC_LO +: 2];
    assign ALTERNATE_PARALLEL_PORT_PINS = dw3[W3_ALT_PMP];
    assign PIN_SELECT_LOCK          = s_r.lock;
    // R19: locked remap rejects writes
    assign PIN_REMAP_WR_OK          = PIN_REMAP_WR & UNLOCK_DONE & ~s_r.lock;

    // ------------------------------------------------------------
    // write screening
    // ------------------------------------------------------------
    // R23: 512-word pages, two address units per word
    assign wr_page    = FLASH_WR_ADDR[FCWL_PAGE_SHIFT +: 14];
    assign bound_page = {6'h00, dw3[W3_BOUND_LO +: 8]};
    assign last_page  = {6'h00, FCWL_LAST_PAGE};
    assign last_hit   = wr_page >= last_page;
    // R21: range from boundary by end select
    assign seg_hit    = dw3[W3_SEG_END] ? (wr_page >= bound_page) : (wr_page <= bound_page);
    // R22: last page protection
    assign seg_block  = !dw3[W3_SEG_DIS] &&
                        (seg_hit || (last_hit && (!dw3[W3_CFG_PAGE] || dw3[W3_SEG_END]
                                                  || bound_page == last_page)));
    // R4: erase of last page clears words; protection follows next load
    assign FLASH_WR_OK = FLASH_WR_REQ & loaded & ~WRITE_PROTECT_ALL & ~seg_block;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_load_done_time: assert property (@(posedge REF_CLK) disable iff (RST) // R1
        (CLK_EN && s_r.state == ST_IDLE) |-> ##[1:40] loaded || !CLK_EN)
        else $error("load did not finish");
    a_first_addr: assert property (@(posedge REF_CLK) disable iff (RST) // R2
        (FLASH_RD && s_r.idx == 2'h0) |-> FLASH_ADDR == FCWL_ADDR_WORD1)
        else $error("wrong first address");
    a_upper_ones: assert property (@(posedge REF_CLK) disable iff (RST) // R3
        CFG_WORD1[23:16] == 8'hFF && CFG_WORD3[23:16] == 8'hFF)
        else $error("upper byte not ones");
    a_busy_ones: assert property (@(posedge REF_CLK) disable iff (RST) // R24
        LOAD_BUSY |-> CFG_WORD2 == FCWL_WORD_RESET && !DEBUG_MODE)
        else $error("defaults not held");
    a_code_prot: assert property (@(posedge REF_CLK) disable iff (RST) // R6
        CODE_PROTECT_ALL == !CFG_WORD1[13])
        else $error("code protect mismatch");
    a_write_block: assert property (@(posedge REF_CLK) disable iff (RST) // R7
        WRITE_PROTECT_ALL |-> !FLASH_WR_OK)
        else $error("write passed while protected");
    a_window_mode: assert property (@(posedge REF_CLK) disable iff (RST) // R10
        WATCHDOG_WINDOW_MODE |-> WATCHDOG_ENABLE)
        else $error("window without watchdog");
    a_lock_oneway: assert property (@(posedge REF_CLK) disable iff (RST) // R19
        (PIN_SELECT_LOCK && CFG_WORD2[4] && CLK_EN) |=> PIN_SELECT_LOCK)
        else $error("one-way lock cleared");
    a_remap_reject: assert property (@(posedge REF_CLK) disable iff (RST) // R19
        PIN_SELECT_LOCK |-> !PIN_REMAP_WR_OK)
        else $error("remap write while locked");
    c_load_done: cover property (@(posedge REF_CLK) disable iff (RST) $rose(loaded));
    c_lock_set: cover property (@(posedge REF_CLK) disable iff (RST) $rose(PIN_SELECT_LOCK));
    c_seg_block: cover property (@(posedge REF_CLK) disable iff (RST) FLASH_WR_REQ && seg_block);
endmodule

// *** fcwl_flash_model.sv ***
`timescale 1ns/1ps
// program flash model serving the configuration words to the loader
// assumes one read strobe per word on the system clock
module fcwl_flash_model
    import fcwl_pkg::*;
#(
    parameter int LAT = 1
)
(
    // clock
    input  wire logic        clk,
    // read port
    input  wire logic        rd,
    input  wire logic [23:0] addr,
    output logic [23:0]      data,
    // stored words and erase state
    input  wire logic [15:0] w1,
    input  wire logic [15:0] w2,
    input  wire logic [15:0] w3,
    input  wire logic        erased
);
    logic [23:0] held_addr = 24'h00_0000;
    logic [23:0] junk      = 24'h5A_A55A;
    int          live      = 0;

    // garbage flips every cycle so a late sample never sees old data
    always @(posedge clk) begin
        junk <= ~junk;
        if (rd === 1'b1) begin
            held_addr <= addr;
            live      <= LAT + 1;
        end else if (live > 0) begin
            live <= live - 1;
        end
    end

    function automatic logic [23:0] word_at(input logic [23:0] a);
        if (erased)
            return 24'h00_0000;
        // upper byte is programmed as zero; the loader must not pass it on
        case (a)
            FCWL_ADDR_WORD1: return {8'h00, w1};
            FCWL_ADDR_WORD2: return {8'h00, w2};
            FCWL_ADDR_WORD3: return {8'h00, w3};
            FCWL_ADDR_WORD4: return 24'h00_FFFF;
            default:         return junk;
        endcase
    endfunction

    always_comb begin
        if (rd === 1'b1)
            data = word_at(addr);
        else if (live > 0)
            data = word_at(held_addr);
        else
            data = junk;
    end
endmodule

// *** flash_config_word_loader_tb_top.sv ***
`timescale 1ns/1ps
// self-checking bench for the configuration word loader
// assumes the flash model file and the design package are compiled first
module flash_config_word_loader_tb_top;
    import fcwl_pkg::*;
    localparam time TCK = 50ns;
    localparam time DLY = 5ns;
    typedef struct {logic [15:0] w1; logic [15:0] w2; logic [4:0] div; logic [15:0] post;
                    logic cksw; logic fsm; logic clock_output_pin;} fcwl_row_type;
    fcwl_row_type rows [8];
    logic        clk = 1'b0, rst = 1'b1, clk_en = 1'b1, erased = 1'b0;
    logic        wr_req = 1'b0, lk_set = 1'b0, lk_clr = 1'b0, unlock = 1'b0, remap = 1'b0, pll_sw = 1'b0;
    logic [23:0] wr_addr = 24'h00_0000;
    logic [15:0] m_w1 = 16'hFFFF, m_w2 = 16'hFFFF, m_w3 = 16'hFFFF;
    logic        rd, wr_ok, remap_ok, lock, busy, tp, cp, wp, dbg, prs, wen, win, p128, aref;
    logic        tsp, prun, ors, csw, fsm, clock_output_pin, apmp;
    logic [23:0] addr, fdata, cw1, cw2, cw3;
    logic [1:0]  pair, posc;
    logic [15:0] post;
    logic [4:0]  div;
    logic [2:0]  osc;
    int          failures = 0, compares = 0, strobes = 0;

    always #(TCK/2) clk = ~clk;
    always @(posedge clk) if (rd === 1'b1 && clk_en) strobes++;

    fcwl_flash_model #(.LAT(1)) flash (.clk(clk), .rd(rd), .addr(addr), .data(fdata),
        .w1(m_w1), .w2(m_w2), .w3(m_w3), .erased(erased));

    fcwl_loader #(.FLASH_LAT(1)) uut (.REF_CLK(clk), .RST(rst), .CLK_EN(clk_en), .FLASH_RD(rd),
        .FLASH_ADDR(addr), .FLASH_DATA(fdata), .FLASH_WR_REQ(wr_req), .FLASH_WR_ADDR(wr_addr),
        .FLASH_WR_OK(wr_ok), .PIN_LOCK_SET(lk_set), .PIN_LOCK_CLR(lk_clr), .UNLOCK_DONE(unlock),
        .PIN_REMAP_WR(remap), .PIN_REMAP_WR_OK(remap_ok), .PIN_SELECT_LOCK(lock),
        .PLL_SOFTWARE_ENABLE(pll_sw), .LOAD_BUSY(busy), .CFG_WORD1(cw1), .CFG_WORD2(cw2),
        .CFG_WORD3(cw3), .TEST_PORT_ENABLE(tp), .CODE_PROTECT_ALL(cp), .WRITE_PROTECT_ALL(wp),
        .DEBUG_MODE(dbg), .EMULATOR_PIN_PAIR_SELECT(pair), .EMULATOR_PAIR_RESERVED(prs),
        .WATCHDOG_ENABLE(wen), .WATCHDOG_WINDOW_MODE(win), .WATCHDOG_PRESCALE_128(p128),
        .WATCHDOG_POSTSCALE_RATIO(post), .ALTERNATE_REFERENCE_PINS(aref),
        .TWO_SPEED_STARTUP_ENABLE(tsp), .PLL_INPUT_DIVIDER(div), .PLL_RUN(prun),
        .INITIAL_OSCILLATOR_SELECT(osc), .INITIAL_OSC_RESERVED(ors), .CLOCK_SWITCH_ENABLE(csw),
        .FAIL_SAFE_MONITOR_ENABLE(fsm), .CLOCK_OUTPUT_PIN(clock_output_pin), .PRIMARY_OSC_MODE(posc),
        .ALTERNATE_PARALLEL_PORT_PINS(apmp));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #DLY;
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_word(input string n, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic do_load();
        int n;
        rst = 1'b1;
        step(5);
        rst = 1'b0;
        clk_en = 1'b0;
        wr_req = 1'b1;
        wr_addr = 24'h00_8000;
        strobes = 0;
        step(4);
        chk_bit("busy frozen", 1'b1, busy);
        chk_word("word1 loading", FCWL_WORD_RESET, cw1);
        chk_bit("write while busy", 1'b0, wr_ok);
        chk_word("strobes frozen", 24'd0, strobes[23:0]);
        clk_en = 1'b1;
        wr_req = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            step(1);
            n++;
        end
        chk_bit("load done", 1'b0, busy);
        chk_word("read strobes", 24'd3, strobes[23:0]);
    endtask

    // request held across an edge so back-to-back probes never retoggle it in one step
    task automatic wr_probe(input logic [23:0] a, input logic e);
        wr_req = 1'b1;
        wr_addr = a;
        #DLY chk_bit("write ok", e, wr_ok);
        step(1);
        wr_req = 1'b0;
        step(1);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        #(TCK * 5000);
        failures++;
        tally_and_finish();
    end

    initial begin
        rows = '{'{16'hFFFF, 16'hFFFF, 5'd12, 16'h8000, 1'b0, 1'b0, 1'b1},
                 '{16'h0680, 16'h666C, 5'd8,  16'h0001, 1'b1, 1'b0, 1'b1},
                 '{16'h7D75, 16'hDD3E, 5'd6,  16'h0020, 1'b1, 1'b1, 1'b0},
                 '{16'h2CDA, 16'h449D, 5'd5,  16'h0400, 1'b0, 1'b0, 1'b0},
                 '{16'h4FF3, 16'hBB4F, 5'd4,  16'h0008, 1'b1, 1'b0, 1'b0},
                 '{16'h1E4C, 16'h2AFC, 5'd3,  16'h1000, 1'b0, 1'b0, 1'b1},
                 '{16'h6F97, 16'h110C, 5'd2,  16'h0080, 1'b1, 1'b1, 1'b0},
                 '{16'h7FFE, 16'h807D, 5'd1,  16'h4000, 1'b1, 1'b0, 1'b0}};
        step(1);
        foreach (rows[i]) begin
            m_w1 = rows[i].w1;
            m_w2 = rows[i].w2;
            m_w3 = ~rows[i].w2;
            do_load();
            chk_word("word1", {8'hFF, m_w1}, cw1);
            chk_word("word2", {8'hFF, m_w2}, cw2);
            chk_word("word3", {8'hFF, m_w3}, cw3);
            chk_bit("test port", m_w1[14], tp);
            chk_bit("code protect", ~m_w1[13], cp);
            chk_bit("write protect", ~m_w1[12], wp);
            chk_bit("debug", ~m_w1[11], dbg);
            chk_word("pin pair", {22'h0, m_w1[9:8]}, {22'h0, pair});
            chk_bit("pair reserved", m_w1[9:8] == 2'b00, prs);
            chk_bit("wdt enable", m_w1[7], wen);
            chk_bit("wdt window", m_w1[7] & ~m_w1[6], win);
            chk_bit("prescale", m_w1[4], p128);
            chk_bit("alt reference", m_w1[5], aref);
            chk_bit("alt pmp", m_w3[12], apmp);
            chk_word("postscale", {8'h0, rows[i].post}, {8'h0, post});
            chk_bit("two speed", m_w2[15], tsp);
            chk_word("pll divider", {19'h0, rows[i].div}, {19'h0, div});
            chk_bit("pll run", m_w2[11], prun);
            chk_word("osc select", {21'h0, m_w2[10:8]}, {21'h0, osc});
            chk_bit("osc reserved", m_w2[10:8] == 3'b110, ors);
            chk_bit("clock switch", rows[i].cksw, csw);
            chk_bit("fail safe", rows[i].fsm, fsm);
            chk_bit("clock out", rows[i].clock_output_pin, clock_output_pin);
            chk_word("posc mode", {22'h0, m_w2[1:0]}, {22'h0, posc});
        end
        pll_sw = 1'b1;
        #DLY chk_bit("pll software", 1'b1, prun);
        step(1);
        pll_sw = 1'b0;
        // erased last page must come back fully protected
        erased = 1'b1;
        do_load();
        chk_word("erased word1", 24'hFF_0000, cw1);
        chk_bit("erased code protect", 1'b1, cp);
        wr_probe(24'h00_8000, 1'b0);
        erased = 1'b0;
        // segmented write protection, boundary at page 0x10, then at page 0x20
        m_w1 = 16'hFFFF;
        m_w2 = 16'hFFFF;
        m_w3 = 16'h0010;
        do_load();
        wr_probe(24'h00_3C00, 1'b0);
        wr_probe(24'h00_4400, 1'b1);
        wr_probe(FCWL_ADDR_WORD2, 1'b0);
        m_w3 = 16'h4010;
        do_load();
        wr_probe(FCWL_ADDR_WORD2, 1'b1);
        m_w3 = 16'hC020;
        do_load();
        wr_probe(24'h00_4000, 1'b1);
        wr_probe(24'h00_C000, 1'b0);
        wr_probe(FCWL_ADDR_WORD1, 1'b0);
        // one-way pin lock
        pulse(lk_set);
        chk_bit("lock without unlock", 1'b0, lock);
        unlock = 1'b1;
        pulse(lk_set);
        remap = 1'b1;
        #DLY chk_bit("remap locked", 1'b0, remap_ok);
        step(1);
        remap = 1'b0;
        pulse(lk_clr);
        chk_bit("lock kept", 1'b1, lock);
        unlock = 1'b0;
        m_w2 = 16'hFFEF;
        do_load();
        unlock = 1'b1;
        pulse(lk_set);
        chk_bit("lock set", 1'b1, lock);
        pulse(lk_clr);
        remap = 1'b1;
        #DLY chk_bit("remap free", 1'b1, remap_ok);
        chk_bit("lock cleared", 1'b0, lock);
        remap = 1'b0;
        tally_and_finish();
    end
endmodule
